// *** bench/host_model.sv ***
// host side model: three-wire and framed serial sender
module host_model (
  input wire logic clk_sys,
  output logic sclk_pin,
  output logic sdata_pin,
  output logic load_pin
);
  timeunit 1ns;
  timeprecision 1ps;
  initial begin
    sclk_pin = 1'b0;
    sdata_pin = 1'b0;
    load_pin = 1'b0;
  end
  // data moves mid-low so it is held well past the synced rise
  task automatic bit_out(input logic b);
    sdata_pin = b;
    repeat (2) @(negedge clk_sys);
    sclk_pin = 1'b1;
    repeat (4) @(negedge clk_sys);
    sclk_pin = 1'b0;
    repeat (2) @(negedge clk_sys);
  endtask
  task automatic latch();
    load_pin = 1'b1;
    repeat (8) @(negedge clk_sys);
    load_pin = 1'b0;
    sdata_pin = ~sdata_pin;
  endtask
  task automatic send_word(input logic [15:0] w);
    for (int i = 15; i >= 0; i--) bit_out(w[i]);
    latch();
  endtask
  task automatic frame(input logic [15:0] w, input logic stop);
    logic b;
    load_pin = 1'b1;
    repeat (20) bit_out(1'b1);
    for (int i = 17; i >= 0; i--) begin
      b = (i == 17) ? 1'b0 : (i == 0) ? stop : w[i-1];
      repeat (16) bit_out(b);
    end
    repeat (16) bit_out(1'b1);
  endtask
endmodule // host_model

// *** bench/loop_dac_front_properties.sv ***
// concurrent checks on the ports of the loop converter front end
module loop_dac_front_properties #(
  parameter WORD_W = 16
) (
  input wire logic clk_sys,
  input wire logic nrst,
  input wire logic sclk_pin,
  input wire logic clear_pin,
  input wire logic [1:0] range_sel,
  input wire logic drive_limit,
  input wire logic sdata_out,
  input wire logic fault_n_o,
  input wire logic fault_n_oe,
  input wire logic sd_bit,
  input wire logic [1:0] range_mode,
  input wire logic current_out,
  input wire logic [WORD_W-1:0] code,
  input wire logic framed_mode
);
  default clocking cb @(posedge clk_sys); endclocking
  default disable iff (!nrst);
  fault_pol_a: assert property (fault_n_o == 1'b0) else $error("fault pin driven high");
  fault_set_a: assert property (drive_limit [*8] |-> fault_n_oe) else $error("fault flag not low");
  fault_clr_a: assert property (!drive_limit [*8] |-> !fault_n_oe) else $error("fault flag stuck");
  clear_min_a: assert property (clear_pin [*8] |-> code == '0) else $error("clear not at minimum");
  range_follow_a: assert property ($stable(range_sel) [*8] |-> range_mode == range_sel)
    else $error("range mode wrong");
  volt_gate_a: assert property (range_mode == 2'h0 |-> !current_out) else $error("current in volt range");
  cur_pass_a: assert property (range_mode != 2'h0 |-> current_out == sd_bit)
    else $error("current switch not fed");
  chain_hold_a: assert property ((!sclk_pin && !framed_mode) [*8] |-> $stable(sdata_out))
    else $error("chain out moved");
endmodule // loop_dac_front_properties
bind loop_dac_front loop_dac_front_properties #(.WORD_W(WORD_W)) i_loop_dac_front_properties (
  .clk_sys(clk_sys), .nrst(nrst), .sclk_pin(sclk_pin), .clear_pin(clear_pin), .range_sel(range_sel),
  .drive_limit(drive_limit), .sdata_out(sdata_out), .fault_n_o(fault_n_o), .fault_n_oe(fault_n_oe),
  .sd_bit(sd_bit), .range_mode(range_mode), .current_out(current_out), .code(code),
  .framed_mode(framed_mode));

// *** bench/tb_loop_dac_front.sv ***
// self-checking bench for the loop converter serial front end
`include "loop_dac_defs.vh"
module tb_loop_dac_front;
  timeunit 1ns;
  timeprecision 1ps;
  logic clk_sys = 1'b0;
  logic nrst = 1'b0;
  logic clear_pin = 1'b0;
  logic drive_limit = 1'b0;
  logic [1:0] range_sel = `RANGE_4_20;
  logic sclk_pin, sdata_pin, load_pin, sdata_out, fault_n_o, fault_n_oe, sd_bit, current_out, framed_mode;
  logic [1:0] range_mode;
  logic code_ready;
  logic [`WORD_W-1:0] code;
  int error_cnt = 0;
  int cmp_count = 0;
  always #20 clk_sys = ~clk_sys;
  host_model i_host_model (.clk_sys(clk_sys), .sclk_pin(sclk_pin), .sdata_pin(sdata_pin), .load_pin(load_pin));
  loop_dac_front i_loop_dac_front (.clk_sys(clk_sys), .nrst(nrst), .ce(1'b1), .sclk_pin(sclk_pin),
    .sdata_pin(sdata_pin), .load_pin(load_pin), .clear_pin(clear_pin), .range_sel(range_sel),
    .drive_limit(drive_limit), .sdata_out(sdata_out), .fault_n_o(fault_n_o), .fault_n_oe(fault_n_oe),
    .sd_bit(sd_bit), .range_mode(range_mode), .current_out(current_out), .code(code),
    .framed_mode(framed_mode), .code_ready(code_ready));
  // ----------------------------------------
  // compare and wait helpers
  // ----------------------------------------
  task automatic tally_and_finish();
    $display("compares %0d mismatches %0d", cmp_count, error_cnt);
    if (error_cnt == 0 && cmp_count > 0) $display("bench passed");
    else $display("bench failed");
    $finish;
  endtask
  task automatic cmp_word(input logic [15:0] got, input logic [15:0] exp);
    cmp_count++;
    if (got !== exp) begin
      error_cnt++;
      $display("mismatch at %0t got %h expected %h", $time, got, exp);
    end
  endtask
  task automatic cmp_flag(input logic got, input logic exp);
    cmp_word({15'h0000, got}, {15'h0000, exp});
  endtask
  // a load lands within a few clocks, so 64 is generous
  task automatic wait_code(input logic [15:0] exp);
    int n;
    n = 0;
    while (code !== exp && n < 64) begin
      @(negedge clk_sys);
      n++;
    end
    cmp_word(code, exp);
    if (code !== exp) tally_and_finish();
  endtask
  task automatic t_shift();
    i_host_model.send_word(16'ha5c3);
    wait_code(16'ha5c3);
    i_host_model.send_word(16'h3c5a);
    wait_code(16'h3c5a);
    cmp_flag(sdata_out, 1'b1);
    cmp_flag(code_ready, 1'b1);
  endtask
  task automatic t_range();
    int ones;
    ones = 0;
    for (int r = 0; r < 4; r++) begin
      range_sel = r[1:0];
      repeat (10) @(negedge clk_sys);
      cmp_word({14'h0000, range_mode}, {14'h0000, r[1:0]});
      cmp_word(code, 16'h3c5a);
    end
    repeat (256) @(negedge clk_sys) ones += sd_bit;
    cmp_flag(ones > 0 && ones < 256, 1'b1);
  endtask
  task automatic t_fault();
    drive_limit = 1'b1;
    repeat (10) @(negedge clk_sys);
    cmp_flag(fault_n_oe, 1'b1);
    cmp_flag(fault_n_o, 1'b0);
    drive_limit = 1'b0;
    repeat (10) @(negedge clk_sys);
    cmp_flag(fault_n_oe, 1'b0);
  endtask
  task automatic t_clear();
    clear_pin = 1'b1;
    wait_code(16'h0000);
    repeat (8) @(negedge clk_sys);
    clear_pin = 1'b0;
    repeat (20) @(negedge clk_sys);
    cmp_word(code, 16'h0000);
    i_host_model.latch();
    wait_code(16'h3c5a);
  endtask
  task automatic t_framed();
    int pulse;
    pulse = 0;
    i_host_model.frame(16'h1234, 1'b1);
    cmp_flag(framed_mode, 1'b1);
    wait_code(16'h1234);
    fork
      i_host_model.frame(16'h4321, 1'b0);
      repeat (3000) @(negedge clk_sys) pulse += sdata_out;
    join
    cmp_word(code, 16'h1234);
    cmp_flag(pulse > 0, 1'b1);
  endtask
  initial begin
    repeat (16) @(negedge clk_sys);
    nrst = 1'b1;
    repeat (8) @(negedge clk_sys);
    t_shift();
    t_range();
    t_fault();
    t_clear();
    t_framed();
    tally_and_finish();
  end
endmodule // tb_loop_dac_front

// *** src/loop_dac_defs.vh ***
// constants for the current-loop converter serial front end
`ifndef LOOP_DAC_DEFS_VH
`define LOOP_DAC_DEFS_VH
`define WORD_W 16
`define OVS 5'h10
`define OVS_HALF 5'h08
`define OVS_LAST 5'h0f
`define BIT_LAST 5'h11
`define RANGE_VOLT 2'h0
`define RANGE_4_20 2'h1
`define RANGE_0_20 2'h2
`define RANGE_0_24 2'h3
`define FIFO_DEPTH 8
`define ST_IDLE 2'h0
`define ST_RECV 2'h1
`define ST_ERR 2'h2
`endif

// *** src/loop_dac_front.v ***
// serial input, latch, range control and sigma-delta modulator of a loop converter
//
// Behaviour
// - shift data in on each sclk rise in three-wire mode
// - load strobe copies shift register to latches
// - sixteen-bit code and input word
// - strobe held high selects framed mode
// - framed word with start/stop makes load
// - active-low open-drain fault flag near limit
// - second-order sigma-delta drives current switch
// - three current ranges supported
// - zero code gives range minimum
// - one clock/bit, or sixteen in framed mode
// - daisy-chain out, or framing error pulse
// - clear forces minimum, shift register kept
`include "loop_dac_defs.vh"
module loop_dac_front #(
  parameter WORD_W = `WORD_W,
  parameter FIFO_DEPTH = `FIFO_DEPTH
) (
  input wire clk_sys,
  input wire nrst,
  input wire ce,
  input wire sclk_pin,
  input wire sdata_pin,
  input wire load_pin,
  input wire clear_pin,
  input wire [1:0] range_sel,
  input wire drive_limit,
  output reg sdata_out,
  output wire fault_n_o,
  output wire fault_n_oe,
  output reg sd_bit,
  output reg [1:0] range_mode,
  output wire current_out,
  output reg [WORD_W-1:0] code,
  output wire framed_mode,
  output wire code_ready
);
  // ----------------------------------------
  // pin synchronisers
  // ----------------------------------------
  // three stages: a change counts once stages two and three agree
  reg [2:0] s_clk;
  reg [2:0] s_dat;
  reg [2:0] s_ld;
  reg [2:0] s_clr;
  reg [2:0] s_lim;
  // the filter flop follows only once two stages agree, so a one-cycle
  // glitch never reaches the edge detectors; ce low freezes every stage
  reg clk_f;
  reg dat_f;
  reg ld_f;
  reg clr_f;
  reg lim_f;
  always @(posedge clk_sys or negedge nrst) begin
    if (!nrst) begin
      s_clk <= 3'h0;
      s_dat <= 3'h0;
      s_ld <= 3'h0;
      s_clr <= 3'h0;
      s_lim <= 3'h0;
      clk_f <= 1'b0;
      dat_f <= 1'b0;
      ld_f <= 1'b0;
      clr_f <= 1'b0;
      lim_f <= 1'b0;
    end else if (ce) begin
      s_clk <= {s_clk[1:0], sclk_pin};
      s_dat <= {s_dat[1:0], sdata_pin};
      s_ld <= {s_ld[1:0], load_pin};
      s_clr <= {s_clr[1:0], clear_pin};
      s_lim <= {s_lim[1:0], drive_limit};
      if (s_clk[1] == s_clk[2]) begin
        clk_f <= s_clk[2];
      end
      if (s_dat[1] == s_dat[2]) begin
        dat_f <= s_dat[2];
      end
      if (s_ld[1] == s_ld[2]) begin
        ld_f <= s_ld[2];
      end
      if (s_clr[1] == s_clr[2]) begin
        clr_f <= s_clr[2];
      end
      if (s_lim[1] == s_lim[2]) begin
        lim_f <= s_lim[2];
      end
    end
  end
  reg clk_d;
  reg ld_d;
  wire sclk_rise = clk_f && !clk_d;
  wire ld_rise = ld_f && !ld_d;
  // ----------------------------------------
  // mode detect
  // ----------------------------------------
  // a host pulses the strobe; a resistor keeps it high, so a long high
  // spanning seventeen sclk edges selects framed mode
  reg [4:0] hi_cnt;
  reg async_md;
  assign framed_mode = async_md;
  always @(posedge clk_sys or negedge nrst) begin
    if (!nrst) begin
      clk_d <= 1'b0;
      ld_d <= 1'b0;
      hi_cnt <= 5'h00;
      async_md <= 1'b0;
    end else if (ce) begin
      clk_d <= clk_f;
      ld_d <= ld_f;
      if (!ld_f) begin
        hi_cnt <= 5'h00;
        async_md <= 1'b0;
      end else if (sclk_rise && hi_cnt != `BIT_LAST) begin
        hi_cnt <= hi_cnt + 5'h01;
      end else if (hi_cnt == `BIT_LAST) begin
        async_md <= 1'b1;
      end
    end
  end
  // ----------------------------------------
  // three-wire shift register
  // ----------------------------------------
  reg [WORD_W-1:0] shreg;
  reg [WORD_W-1:0] hold;
  reg err_pulse;
  always @(posedge clk_sys or negedge nrst) begin
    if (!nrst) begin
      shreg <= {WORD_W{1'b0}};
      sdata_out <= 1'b0;
    end else if (ce) begin
      if (!async_md && sclk_rise) begin
        shreg <= {shreg[WORD_W-2:0], dat_f};
        // the bit leaving the top feeds the next converter of a chain
        sdata_out <= shreg[WORD_W-1];
      end else if (async_md) begin
        sdata_out <= err_pulse;
      end
    end
  end
  // ----------------------------------------
  // framed receiver, 16x oversampled
  // ----------------------------------------
  reg [1:0] rx_st;
  reg [1:0] next_rx_st;
  reg [4:0] ph;
  reg [4:0] bitn;
  reg [WORD_W-1:0] rx_sh;
  reg fr_valid;
  always @* begin
    next_rx_st = rx_st;
    case (rx_st)
      `ST_IDLE: begin
        if (sclk_rise && !dat_f) begin
          next_rx_st = `ST_RECV;
        end
      end
      `ST_RECV: begin
        if (sclk_rise && ph == `OVS_LAST && bitn == `BIT_LAST) begin
          next_rx_st = `ST_IDLE;
        end
      end
      `ST_ERR: next_rx_st = `ST_IDLE;
      default: next_rx_st = `ST_IDLE;
    endcase
  end
  always @(posedge clk_sys or negedge nrst) begin
    if (!nrst) begin
      rx_st <= `ST_IDLE;
      ph <= 5'h00;
      bitn <= 5'h00;
      rx_sh <= {WORD_W{1'b0}};
      err_pulse <= 1'b0;
      fr_valid <= 1'b0;
    end else if (ce) begin
      fr_valid <= 1'b0;
      if (!async_md) begin
        rx_st <= `ST_IDLE;
        err_pulse <= 1'b0;
      end else begin
        rx_st <= next_rx_st;
        if (sclk_rise) begin
          err_pulse <= 1'b0;
          if (rx_st == `ST_IDLE) begin
            ph <= 5'h01;
            bitn <= 5'h00;
          end else if (rx_st == `ST_RECV) begin
            if (ph == `OVS_LAST) begin
              ph <= 5'h00;
              bitn <= bitn + 5'h01;
            end else begin
              ph <= ph + 5'h01;
            end
            if (ph == `OVS_HALF) begin
              // sample mid-bit: bit 0 start, 1..16 data msb first, 17 stop
              if (bitn == 5'h00) begin
                // a high start sample was a glitch: drop back and hunt again
                if (dat_f) begin
                  rx_st <= `ST_IDLE;
                end
              end else if (bitn != `BIT_LAST) begin
                rx_sh <= {rx_sh[WORD_W-2:0], dat_f};
              end else if (dat_f) begin
                fr_valid <= 1'b1;
              end else begin
                err_pulse <= 1'b1;
              end
            end
          end
        end
      end
    end
  end
  // ----------------------------------------
  // word fifo and dac code register
  // ----------------------------------------
  // back-pressure: a full fifo refuses, which drops that word; the
  // fifo drains one word per clock so it only fills while clear holds it off
  // pointer width of the fifo, enough to index FIFO_DEPTH words
  localparam FIFO_AW = $clog2(FIFO_DEPTH);
  wire load_req = async_md ? fr_valid : ld_rise;
  wire [WORD_W-1:0] load_word = async_md ? rx_sh : shreg;
  wire fifo_in_ready;
  wire fifo_valid;
  wire [WORD_W-1:0] fifo_data;
  word_fifo #(.WIDTH(WORD_W), .DEPTH(FIFO_DEPTH), .AW(FIFO_AW)) i_word_fifo (
    .clk_sys(clk_sys),
    .nrst(nrst),
    .ce(ce),
    .in_valid(load_req),
    .in_ready(fifo_in_ready),
    .in_data(load_word),
    .out_valid(fifo_valid),
    .out_ready(!clr_f),
    .out_data(fifo_data)
  );
  assign code_ready = fifo_in_ready;
  // ----------------------------------------
  // code register and range select
  // ----------------------------------------
  // clear wins over a waiting word and holds the fifo off; limitation:
  // a word queued while clear is high lands once clear is released
  always @(posedge clk_sys or negedge nrst) begin
    if (!nrst) begin
      code <= {WORD_W{1'b0}};
      hold <= {WORD_W{1'b0}};
    end else if (ce) begin
      if (clr_f) begin
        code <= {WORD_W{1'b0}};
      end else if (fifo_valid) begin
        // takes the copy the fifo stored at the load, so sclk may move across this step
        code <= fifo_data;
        hold <= fifo_data;
      end
    end
  end
  // range changes leave the code alone; only the switch gating follows
  always @(posedge clk_sys or negedge nrst) begin
    if (!nrst) begin
      range_mode <= `RANGE_VOLT;
    end else if (ce) begin
      range_mode <= range_sel;
    end
  end
  // ----------------------------------------
  // second-order sigma-delta modulator
  // ----------------------------------------
  // two guard bits let the integrators swing below zero without
  // wrapping; the top bit of each reads as its sign
  reg [WORD_W+1:0] acc1;
  reg [WORD_W+1:0] acc2;
  wire [WORD_W+1:0] code_ext = {2'b00, code};
  wire [WORD_W+1:0] fb = sd_bit ? {2'b01, {WORD_W{1'b0}}} : {WORD_W+2{1'b0}};
  wire [WORD_W+1:0] next_acc1 = acc1 + code_ext - fb;
  wire [WORD_W+1:0] next_acc2 = acc2 + next_acc1 - fb;
  wire acc2_neg = next_acc2[WORD_W+1];
  wire next_sd_bit = !acc2_neg && (next_acc2[WORD_W:0] >= {1'b0, {WORD_W{1'b1}}});
  always @(posedge clk_sys or negedge nrst) begin
    if (!nrst) begin
      acc1 <= {WORD_W+2{1'b0}};
      acc2 <= {WORD_W+2{1'b0}};
      sd_bit <= 1'b0;
    end else if (ce) begin
      acc1 <= next_acc1;
      acc2 <= next_acc2;
      sd_bit <= next_sd_bit;
    end
  end
  // ----------------------------------------
  // current switch
  // ----------------------------------------
  // the voltage range works from the buffer pin, so the loop switch stays open
  assign current_out = sd_bit && (range_mode != `RANGE_VOLT);
  // ----------------------------------------
  // fault flag
  // ----------------------------------------
  // only ever pulled low, so several converters can share one pull-up
  assign fault_n_o = 1'b0;
  assign fault_n_oe = lim_f;
endmodule // loop_dac_front

// *** src/word_fifo.v ***
// small flip-flop fifo with valid/ready on both sides
module word_fifo #(
  parameter WIDTH = 16,
  parameter DEPTH = 8,
  parameter AW = 3
) (
  input wire clk_sys,
  input wire nrst,
  input wire ce,
  input wire in_valid,
  output wire in_ready,
  input wire [WIDTH-1:0] in_data,
  output wire out_valid,
  input wire out_ready,
  output wire [WIDTH-1:0] out_data
);
  reg [WIDTH-1:0] mem [0:DEPTH-1];
  reg [AW-1:0] wp;
  reg [AW-1:0] rp;
  reg [AW:0] cnt;
  wire push;
  wire pop;
  assign in_ready = (cnt != DEPTH[AW:0]);
  assign out_valid = (cnt != {(AW+1){1'b0}});
  assign out_data = mem[rp];
  assign push = in_valid && in_ready;
  assign pop = out_valid && out_ready;
  always @(posedge clk_sys) begin
    if (ce && push) begin
      mem[wp] <= in_data;
    end
  end
  always @(posedge clk_sys or negedge nrst) begin
    if (!nrst) begin
      wp <= {AW{1'b0}};
      rp <= {AW{1'b0}};
      cnt <= {(AW+1){1'b0}};
    end else if (ce) begin
      if (push) begin
        wp <= (wp == DEPTH[AW-1:0] - 1'b1) ? {AW{1'b0}} : wp + 1'b1;
      end
      if (pop) begin
        rp <= (rp == DEPTH[AW-1:0] - 1'b1) ? {AW{1'b0}} : rp + 1'b1;
      end
      if (push && !pop) begin
        cnt <= cnt + 1'b1;
      end else if (pop && !push) begin
        cnt <= cnt - 1'b1;
      end
    end
  end
endmodule // word_fifo
